// ### hw/bgcg_guard.sv
// three-phase gate command guard: input sync, enable filter, lockouts
`timescale 1ns/1ps
module bgcg_guard #(
    parameter int DEAD_CYC = bgcg_pkg::DEAD_INTERVAL_CYC,
    parameter int EN_MIN_CYC = bgcg_pkg::ENABLE_MIN_WIDTH_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] high_side_cmd,
    input wire logic [2:0] low_side_cmd,
    input wire logic enable,
    input wire logic logic_supply_above_rise,
    input wire logic logic_supply_low,
    input wire logic [2:0] floating_supply_above_rise,
    input wire logic [2:0] floating_supply_low,
    output logic [2:0] high_side_gate,
    output logic [2:0] low_side_gate,
    output logic fault_n_out,
    output logic fault_n_oe
);
    localparam int NP = bgcg_pkg::NUM_PHASES;
    localparam int EW = $clog2(EN_MIN_CYC + 1);
    localparam logic [EW-1:0] EN_LAST = EW'(EN_MIN_CYC - 1);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------

    // one sample of every asynchronous input
    typedef struct packed {
        logic [2:0] hi;
        logic [2:0] lo;
        logic en;
        logic vcc_rise;
        logic vcc_low;
        logic [2:0] vb_rise;
        logic [2:0] vb_low;
    } bgcg_pins_type;

    typedef struct packed {
        bgcg_pins_type sync1;
        bgcg_pins_type sync2;
        logic en_filt;
        logic [EW-1:0] en_cnt;
        logic vcc_lock;
        logic [2:0] vb_lock;
    } bgcg_top_state_type;

    bgcg_top_state_type s_r;
    bgcg_top_state_type s_nxt;
    bgcg_pins_type pins;
    logic allow;

    // gather the pins into one word for the synchroniser
    always_comb begin
        pins.hi = high_side_cmd;
        pins.lo = low_side_cmd;
        pins.en = enable;
        pins.vcc_rise = logic_supply_above_rise;
        pins.vcc_low = logic_supply_low;
        pins.vb_rise = floating_supply_above_rise;
        pins.vb_low = floating_supply_low;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        // two-stage input sync
        // every pin, supplies included, pays the same two cycles, but a lockout then
        // passes its lock register, so it lags the command that it has to stop by one cycle
        s_nxt.sync1 = pins;
        s_nxt.sync2 = s_r.sync1;

        // reject short enable changes
        // a real shutdown is held back by the filter width as well; the
        // controller must budget for that delay on top of the sync cycles
        if (s_r.sync2.en != s_r.en_filt) begin
            if (s_r.en_cnt == EN_LAST) begin
                s_nxt.en_filt = s_r.sync2.en;
                s_nxt.en_cnt = '0;
            end else begin
                s_nxt.en_cnt = s_r.en_cnt + EW'(1);
            end
        end else begin
            // any bounce back restarts the width count
            s_nxt.en_cnt = '0;
        end

        // engage low, release high
        // low wins when both comparators read set, so a noisy supply stays locked
        if (s_r.sync2.vcc_low) begin
            s_nxt.vcc_lock = 1'b1;
        end else if (s_r.sync2.vcc_rise) begin
            s_nxt.vcc_lock = 1'b0;
        end
        for (int i = 0; i < NP; i++) begin
            if (s_r.sync2.vb_low[i]) begin
                s_nxt.vb_lock[i] = 1'b1;
            end else if (s_r.sync2.vb_rise[i]) begin
                s_nxt.vb_lock[i] = 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------

    // lockouts start engaged so nothing drives before the supplies settle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r.sync1 <= '0;
            s_r.sync2 <= '0;
            s_r.en_filt <= bgcg_pkg::ENABLE_RST;
            s_r.en_cnt <= '0;
            s_r.vcc_lock <= bgcg_pkg::LOCK_RST;
            s_r.vb_lock <= {NP{bgcg_pkg::LOCK_RST}};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // gating and fault pin
    // ----------------------------------------------------------------

    assign allow = s_r.en_filt && !s_r.vcc_lock;
    // floating lockouts stay out of allow: they must not stop the low side

    // open drain: only ever pulls low, released otherwise
    assign fault_n_out = 1'b0;
    assign fault_n_oe = s_r.vcc_lock;

    // ----------------------------------------------------------------
    // phase legs
    // ----------------------------------------------------------------

    // every leg gets the same count
    for (genvar g = 0; g < NP; g++) begin : g_leg
        bgcg_phase_if pif();

        assign pif.cmd_hi = s_r.sync2.hi[g];
        assign pif.cmd_lo = s_r.sync2.lo[g];
        assign pif.allow = allow;
        // floating lockout hits high side only
        assign pif.hs_ok = !s_r.vb_lock[g];
        assign high_side_gate[g] = pif.gate_hi;
        assign low_side_gate[g] = pif.gate_lo;

        // fixed dead count, no software path
        bgcg_phase #(
            .DEAD_CYC(DEAD_CYC)
        ) u_leg (
            .clk(clk),
            .rst(rst),
            .bus(pif.leg)
        );
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // all checks share the system clock and rest while reset is applied;
    // they look at registered state, so each one names the edge it expects
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // helper: cycles that the filtered enable has been low
    logic [7:0] en_low_run_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_low_run_r <= 8'h00;
        end else if (s_r.en_filt) begin
            en_low_run_r <= 8'h00;
        end else if (en_low_run_r != 8'hFF) begin
            en_low_run_r <= en_low_run_r + 8'h01;
        end
    end

    a_enable_filter_width: assert property (
        $changed(s_r.en_filt) |-> $past(s_r.en_cnt) == EN_LAST)
        else $error("enable filter changed before its width");
    a_enable_short_glitch: assert property (
        (s_r.en_filt && !s_r.sync2.en && s_r.en_cnt != EN_LAST) ##1 s_r.sync2.en
        |=> s_r.en_filt)
        else $error("short enable low was not ignored");
    a_enable_low_off: assert property (
        (en_low_run_r >= 8'h02) |-> high_side_gate == 3'h0 && low_side_gate == 3'h0)
        else $error("gate on while enable filtered low");
    a_vcc_lock_fault: assert property (
        s_r.sync2.vcc_low |=> fault_n_oe && !fault_n_out)
        else $error("fault not pulled low on logic lockout");
    a_vcc_lock_gates: assert property (
        s_r.vcc_lock |=> high_side_gate == 3'h0 && low_side_gate == 3'h0)
        else $error("gate on during logic lockout");
    a_vcc_release: assert property (
        (s_r.sync2.vcc_rise && !s_r.sync2.vcc_low) |=> !fault_n_oe)
        else $error("fault pin not released after recovery");
    a_lock_hysteresis: assert property (
        (!s_r.sync2.vcc_rise && !s_r.sync2.vcc_low) |=> $stable(s_r.vcc_lock))
        else $error("logic lockout moved between thresholds");
    a_float_keeps_low: assert property (
        (s_r.vb_lock[1] && low_side_gate[1] && allow && s_r.sync2.lo[1]
         && !s_r.sync2.hi[1]) |=> low_side_gate[1])
        else $error("floating lockout dropped a low gate");

    a_vb_lock_high_off: assert property (
        s_r.vb_lock[1] |=> !high_side_gate[1])
        else $error("high gate on before floating supply ready");

    a_float_off_first: assert property (
        s_r.vb_lock[0] |=> !high_side_gate[0])
        else $error("first high gate on in floating lockout");

    a_float_off_last: assert property (
        s_r.vb_lock[2] |=> !high_side_gate[2])
        else $error("last high gate on in floating lockout");

    a_float_no_fault: assert property (
        (!s_r.vcc_lock && !s_r.sync2.vcc_low) |=> !fault_n_oe)
        else $error("fault pin pulled without logic lockout");

    a_high_float_ready: assert property (
        $rose(high_side_gate[0]) |-> !$past(s_r.vb_lock[0]))
        else $error("high gate rose under floating lockout");

    a_low_needs_allow: assert property (
        $rose(low_side_gate[1]) |-> $past(s_r.en_filt) && !$past(s_r.vcc_lock))
        else $error("low gate rose while not allowed");

    a_enable_hold: assert property (
        (s_r.sync2.en == s_r.en_filt) |=> $stable(s_r.en_filt))
        else $error("filtered enable moved without a pin change");

    // ----------------------------------------------------------------
    // lockout checks
    // ----------------------------------------------------------------

    a_vcc_engage: assert property (
        s_r.sync2.vcc_low |=> s_r.vcc_lock)
        else $error("logic lockout did not engage");

    a_vcc_unlatched: assert property (
        (s_r.sync2.vcc_rise && !s_r.sync2.vcc_low) |=> !s_r.vcc_lock)
        else $error("logic lockout stayed latched");

    a_vcc_gates_soon: assert property (
        $rose(s_r.sync2.vcc_low) |-> ##2 (high_side_gate == 3'h0 && low_side_gate == 3'h0))
        else $error("gates still on two cycles into logic lockout");

    a_float_engage: assert property (
        s_r.sync2.vb_low[2] |=> s_r.vb_lock[2])
        else $error("floating lockout did not engage");

    a_float_release: assert property (
        (s_r.sync2.vb_rise[2] && !s_r.sync2.vb_low[2]) |=> !s_r.vb_lock[2])
        else $error("floating lockout did not release");

    a_float_hold: assert property (
        (!s_r.sync2.vb_rise[2] && !s_r.sync2.vb_low[2]) |=> $stable(s_r.vb_lock[2]))
        else $error("floating lockout moved between thresholds");

    // ----------------------------------------------------------------
    // input path checks
    // ----------------------------------------------------------------

    // the first two edges after reset still see the reset contents of the
    // synchroniser, so the latency checks wait for them to pass
    a_sync_latency: assert property (
        (!$past(rst) && !$past(rst, 2)) |-> s_r.sync2.hi == $past(pins.hi, 2))
        else $error("command sync is not two stages");

    a_sync_low_latency: assert property (
        (!$past(rst) && !$past(rst, 2)) |-> s_r.sync2.lo == $past(pins.lo, 2))
        else $error("low command sync is not two stages");

    a_sync_en_latency: assert property (
        (!$past(rst) && !$past(rst, 2)) |-> s_r.sync2.en == $past(pins.en, 2))
        else $error("enable sync is not two stages");

    a_sync_supply_latency: assert property (
        (!$past(rst) && !$past(rst, 2)) |-> s_r.sync2.vcc_low == $past(pins.vcc_low, 2)
         && s_r.sync2.vb_low == $past(pins.vb_low, 2))
        else $error("supply sync is not two stages");

    c_enable_shutdown: cover property (s_r.en_filt ##1 !s_r.en_filt);
    c_vcc_lockout: cover property (!s_r.vcc_lock ##1 s_r.vcc_lock ##[1:50] !s_r.vcc_lock);
    c_normal_drive: cover property (high_side_gate[0] ##[1:50] low_side_gate[0]);

endmodule // bgcg_guard

// ### include/bgcg_pkg.sv
// constants and shared types for the bridge gate command guard
//
// Overview of operation
// - A gap shorter than the dead interval between one switch turning off and the other turning on is stretched to that interval.
// - A gap between complementary switches that is already longer than the dead interval passes unchanged.
// - While the inserted dead interval runs, both gates of the phase stay off.
// - The dead interval is a fixed length that software cannot change.
// - The same dead interval applies to both directions and to all three phases.
// - Command 1/0 drives only the high gate, 0/1 only the low gate, and 0/0 or 1/1 keeps both gates off.
// - Commands are non-inverting, so a high command gives a high gate.
// - Gates work normally while enable is high and no fault is present, and are all off once enable has stayed low for the filter width.
// - After power-up all gates stay off until the logic supply, or for the high side the floating supply, passes its rising threshold.
// - A logic supply falling below its falling threshold turns off every gate.
// - A logic supply lockout pulls the fault output low.
// - A floating supply below its threshold turns off only that phase's high gate.
// - Each lockout engages at the falling threshold and releases at the rising one, giving hysteresis.
// - After a floating supply lockout clears, the high gate waits for a new rising edge of its command.
// - The logic supply lockout is not latched, and the fault output is released once the supply recovers.
package bgcg_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int DEAD_INTERVAL_NS = 290;
    // least times round up to whole cycles
    localparam int DEAD_INTERVAL_CYC = (DEAD_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ENABLE_MIN_WIDTH_NS = 1000;
    localparam int ENABLE_MIN_WIDTH_CYC =
        (ENABLE_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // structure and reset values
    // ----------------------------------------------------------------
    localparam int NUM_PHASES = 3;
    localparam logic LOCK_RST = 1'b1;
    localparam logic ENABLE_RST = 1'b0;
    localparam logic ARMED_RST = 1'b0;
    localparam logic LAST_HIGH_RST = 1'b0;

    // conduction state of one half-bridge leg
    typedef enum logic [1:0] {
        BGCG_LEG_OFF = 2'b00,
        BGCG_LEG_HIGH = 2'b01,
        BGCG_LEG_LOW = 2'b10
    } bgcg_leg_type;

endpackage

// ### include/bgcg_phase_if.sv
// signals between the guard top and one phase leg
`timescale 1ns/1ps
interface bgcg_phase_if;
    logic cmd_hi;
    logic cmd_lo;
    logic allow;
    logic hs_ok;
    logic gate_hi;
    logic gate_lo;

    modport ctrl (output cmd_hi, output cmd_lo, output allow, output hs_ok,
                  input gate_hi, input gate_lo);
    modport leg (input cmd_hi, input cmd_lo, input allow, input hs_ok,
                 output gate_hi, output gate_lo);
endinterface

// ### hw/bgcg_phase.sv
// one phase leg: shoot-through block, dead interval and high-side rearm
`timescale 1ns/1ps
module bgcg_phase #(
    parameter int DEAD_CYC = bgcg_pkg::DEAD_INTERVAL_CYC
) (
    input wire logic clk,
    input wire logic rst,
    bgcg_phase_if.leg bus
);
    localparam int CW = $clog2(DEAD_CYC + 1);
    localparam logic [CW-1:0] DEAD_LAST = CW'(DEAD_CYC - 1);

    typedef struct packed {
        bgcg_pkg::bgcg_leg_type st;
        logic last_hi;
        logic [CW-1:0] cnt;
        logic armed;
        logic prev_hi;
    } bgcg_leg_state_type;

    bgcg_leg_state_type s_r;
    bgcg_leg_state_type s_nxt;
    logic want_hi;
    logic want_lo;
    logic gap_done;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.prev_hi = bus.cmd_hi;
        if (!bus.hs_ok) begin
            s_nxt.armed = 1'b0;
        end else if (bus.cmd_hi && !s_r.prev_hi) begin
            s_nxt.armed = 1'b1;
        end
        want_hi = bus.cmd_hi && !bus.cmd_lo && bus.allow && bus.hs_ok && s_nxt.armed;
        want_lo = bus.cmd_lo && !bus.cmd_hi && bus.allow;
        gap_done = (s_r.cnt == DEAD_LAST);
        // long gap passes
        // off time counts up and saturates, so a long gap is never stretched
        if (s_r.st != bgcg_pkg::BGCG_LEG_OFF) begin
            s_nxt.cnt = '0;
        end else if (!gap_done) begin
            s_nxt.cnt = s_r.cnt + CW'(1);
        end
        case (s_r.st)
            bgcg_pkg::BGCG_LEG_HIGH: begin
                if (!want_hi) begin
                    s_nxt.st = bgcg_pkg::BGCG_LEG_OFF;
                end
            end
            bgcg_pkg::BGCG_LEG_LOW: begin
                if (!want_lo) begin
                    s_nxt.st = bgcg_pkg::BGCG_LEG_OFF;
                end
            end
            bgcg_pkg::BGCG_LEG_OFF: begin
                // hold other side until gap done
                if (want_hi && (s_r.last_hi || gap_done)) begin
                    s_nxt.st = bgcg_pkg::BGCG_LEG_HIGH;
                    s_nxt.last_hi = 1'b1;
                end else if (want_lo && (!s_r.last_hi || gap_done)) begin
                    s_nxt.st = bgcg_pkg::BGCG_LEG_LOW;
                    s_nxt.last_hi = 1'b0;
                end
            end
            default: s_nxt.st = bgcg_pkg::BGCG_LEG_OFF;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r.st <= bgcg_pkg::BGCG_LEG_OFF;
            s_r.last_hi <= bgcg_pkg::LAST_HIGH_RST;
            s_r.cnt <= DEAD_LAST;
            s_r.armed <= bgcg_pkg::ARMED_RST;
            s_r.prev_hi <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bus.gate_hi = (s_r.st == bgcg_pkg::BGCG_LEG_HIGH);
    assign bus.gate_lo = (s_r.st == bgcg_pkg::BGCG_LEG_LOW);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_no_cross_conduct: assert property (!(bus.gate_hi && bus.gate_lo))
        else $error("both gates on");
    a_dead_low_wait: assert property (
        (s_r.st == bgcg_pkg::BGCG_LEG_OFF && s_r.last_hi && s_r.cnt != DEAD_LAST)
        |=> !bus.gate_lo) else $error("low gate on inside dead interval");
    a_dead_high_wait: assert property (
        (s_r.st == bgcg_pkg::BGCG_LEG_OFF && !s_r.last_hi && s_r.cnt != DEAD_LAST)
        |=> !bus.gate_hi) else $error("high gate on inside dead interval");
    a_long_gap_pass: assert property (
        (s_r.st == bgcg_pkg::BGCG_LEG_OFF && gap_done && bus.cmd_lo && !bus.cmd_hi
         && bus.allow) |=> bus.gate_lo) else $error("long gap delayed");
    a_hs_lock_off: assert property (!bus.hs_ok |=> !bus.gate_hi)
        else $error("high gate on in floating lockout");
    a_hs_rearm_wait: assert property (
        !bus.hs_ok ##1 (bus.hs_ok && bus.cmd_hi && s_r.prev_hi) |=> !bus.gate_hi)
        else $error("high gate on without new command edge");
    a_allow_off: assert property (!bus.allow |=> !bus.gate_hi && !bus.gate_lo)
        else $error("gate on while not allowed");
    c_dead_inserted: cover property (bus.gate_hi ##1 !bus.gate_hi && bus.cmd_lo
                                     ##[1:20] bus.gate_lo);
    c_hs_rearm: cover property (!bus.hs_ok ##1 bus.hs_ok ##[1:20] bus.gate_hi);

endmodule // bgcg_phase

// ### verification/bgcg_ctrl_model.sv
// controller-side model: drives phase commands and a shutdown-safe enable
`timescale 1ns/1ps
module bgcg_ctrl_model #(
    parameter int MIN_LOW = 5
) (
    input wire logic clk,
    input wire logic [2:0] hi_req,
    input wire logic [2:0] lo_req,
    input wire logic run_req,
    input wire logic short_ok,
    output logic [2:0] high_side_cmd,
    output logic [2:0] low_side_cmd,
    output logic enable
);
    int low_cnt = 0;

    // commands are plain levels and pass straight to the pins
    assign high_side_cmd = hi_req;
    assign low_side_cmd = lo_req;

    // enable low width
    // a shutdown is held low for the full width so the filter cannot drop it;
    // short_ok lets a scenario send a deliberately short glitch
    always @(negedge clk) begin
        if (!run_req) begin
            low_cnt <= MIN_LOW;
        end else if (low_cnt != 0) begin
            low_cnt <= low_cnt - 1;
        end
    end
    assign enable = run_req && (low_cnt == 0 || short_ok);
endmodule // bgcg_ctrl_model

// ### verification/tb_bgcg_guard.sv
// self-checking testbench for the three-phase gate command guard
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("wrong value %s expected %0h seen %0h", nm, exp, got); \
    end \
end
module tb_bgcg_guard;
    localparam int DEAD = 3;
    localparam int ENMIN = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] hi_req = 3'h1;
    logic [2:0] lo_req = 3'h2;
    logic run_req = 1'b1;
    logic short_ok = 1'b0;
    logic ls_above = 1'b0;
    logic ls_low = 1'b1;
    logic [2:0] fs_above = 3'h0;
    logic [2:0] fs_low = 3'h7;
    logic [2:0] hcmd;
    logic [2:0] lcmd;
    logic en;
    logic [2:0] hg;
    logic [2:0] lg;
    logic f_out;
    logic f_oe;
    wire fault_pin;
    int num_errors = 0;
    int check_count = 0;

    // 40 MHz clock
    always #12.5 clk = ~clk;
    // the fault pin has a pull-up; the guard only ever pulls it low
    assign fault_pin = f_oe ? f_out : 1'b1;

    bgcg_ctrl_model #(.MIN_LOW(ENMIN + 1)) i_bgcg_ctrl_model (
        .clk(clk), .hi_req(hi_req), .lo_req(lo_req), .run_req(run_req),
        .short_ok(short_ok), .high_side_cmd(hcmd), .low_side_cmd(lcmd), .enable(en));

    bgcg_guard #(.DEAD_CYC(DEAD), .EN_MIN_CYC(ENMIN)) i_bgcg_guard (
        .clk(clk), .rst(rst), .high_side_cmd(hcmd), .low_side_cmd(lcmd), .enable(en),
        .logic_supply_above_rise(ls_above), .logic_supply_low(ls_low),
        .floating_supply_above_rise(fs_above), .floating_supply_low(fs_low),
        .high_side_gate(hg), .low_side_gate(lg), .fault_n_out(f_out), .fault_n_oe(f_oe));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // commands change on a falling edge, clear of the sampling edge
    task automatic set_cmd(input logic [2:0] h, input logic [2:0] l);
        @(negedge clk);
        hi_req <= h;
        lo_req <= l;
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    // supplies come up in steps; the middle step sits between the thresholds
    task automatic t_power_up;
        wait_cyc(10);
        `CHK("gates at power up", 6'h00, {hg, lg})
        `CHK("fault pin at power up", 1'b0, fault_pin)
        ls_low <= 1'b0;
        wait_cyc(10);
        `CHK("fault pin between thresholds", 1'b0, fault_pin)
        ls_above <= 1'b1;
        wait_cyc(6);
        `CHK("fault pin released", 1'b1, fault_pin)
        `CHK("low gates after logic supply up", 3'h2, lg)
        `CHK("high gates with floating low", 3'h0, hg)
        fs_low <= 3'h0;
        wait_cyc(10);
        `CHK("high gates between thresholds", 3'h0, hg)
        fs_above <= 3'h7;
        wait_cyc(8);
        `CHK("high gate without new edge", 3'h0, hg)
        set_cmd(3'h0, 3'h2);
        set_cmd(3'h1, 3'h2);
        wait_cyc(3);
        `CHK("high gate after new edge", 3'h1, hg)
    endtask

    // all four command codes on every phase at once
    task automatic t_truth;
        logic [1:0] c;
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            set_cmd({3{c[1]}}, {3{c[0]}});
            wait_cyc(DEAD + 4);
            `CHK("high gates by code", (c == 2'h2) ? 3'h7 : 3'h0, hg)
            `CHK("low gates by code", (c == 2'h1) ? 3'h7 : 3'h0, lg)
        end
    endtask

    // instant swap in both directions; the gap must be stretched exactly
    task automatic t_dead;
        for (int d = 0; d < 2; d++) begin
            set_cmd(d ? 3'h0 : 3'h7, d ? 3'h7 : 3'h0);
            wait_cyc(DEAD + 5);
            set_cmd(d ? 3'h7 : 3'h0, d ? 3'h0 : 3'h7);
            wait_cyc(3);
            `CHK("both off at swap", 6'h00, {hg, lg})
            wait_cyc(DEAD - 1);
            `CHK("both off end of dead", 6'h00, {hg, lg})
            wait_cyc(1);
            `CHK("new side after dead", d ? 6'h38 : 6'h07, {hg, lg})
        end
    endtask

    // a gap already longer than the dead interval gets no extra delay
    task automatic t_gap;
        set_cmd(3'h0, 3'h0);
        wait_cyc(DEAD + 2);
        set_cmd(3'h0, 3'h7);
        wait_cyc(2);
        `CHK("low gates before latency", 3'h0, lg)
        wait_cyc(1);
        `CHK("low gates after long gap", 3'h7, lg)
    endtask

    // a short enable glitch is ignored, a full-width shutdown is not
    task automatic t_enable;
        @(negedge clk);
        short_ok <= 1'b1;
        run_req <= 1'b0;
        wait_cyc(2);
        run_req <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            wait_cyc(1);
            `CHK("low gates through glitch", 3'h7, lg)
        end
        short_ok <= 1'b0;
        run_req <= 1'b0;
        wait_cyc(ENMIN + 4);
        `CHK("gates on shutdown", 6'h00, {hg, lg})
        run_req <= 1'b1;
        wait_cyc(2 * ENMIN + 6);
        `CHK("gates after enable", 3'h7, lg)
    endtask

    // logic supply dips and recovers; nothing is latched
    task automatic t_logic_low;
        set_cmd(3'h1, 3'h6);
        wait_cyc(DEAD + 4);
        `CHK("gates before dip", 6'h0E, {hg, lg})
        ls_low <= 1'b1;
        wait_cyc(5);
        `CHK("gates in logic lockout", 6'h00, {hg, lg})
        `CHK("fault pin in lockout", 1'b0, fault_pin)
        ls_low <= 1'b0;
        wait_cyc(6);
        `CHK("fault pin after recovery", 1'b1, fault_pin)
        `CHK("low gates after recovery", 3'h6, lg)
    endtask

    // one floating supply dips: only that high gate goes off, and stays off
    task automatic t_float;
        set_cmd(3'h0, 3'h6);
        set_cmd(3'h1, 3'h6);
        wait_cyc(4);
        fs_low <= 3'h1;
        fs_above <= 3'h6;
        wait_cyc(5);
        `CHK("gates in floating lockout", 6'h06, {hg, lg})
        fs_low <= 3'h0;
        fs_above <= 3'h7;
        wait_cyc(8);
        `CHK("high gate after clear", 3'h0, hg)
        set_cmd(3'h0, 3'h6);
        set_cmd(3'h1, 3'h6);
        wait_cyc(3);
        `CHK("high gate rearmed", 3'h1, hg)
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    // reset for six cycles, then every scenario in turn
    initial begin
        wait_cyc(6);
        rst <= 1'b0;
        t_power_up();
        t_truth();
        t_dead();
        t_gap();
        t_enable();
        t_logic_low();
        t_float();
        finish_test();
    end

    // the scenarios need well under 500 cycles; a hang is cut at 3000
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        finish_test();
    end
endmodule // tb_bgcg_guard
